// File: shared/oul_regs.vh
`ifndef OUL_REGS_VH
`define OUL_REGS_VH

// Register select codes on the 3-bit host address.
`define OUL_ADDR_DATA 3'h0
`define OUL_ADDR_STATUS 3'h1
`define OUL_ADDR_MODE 3'h2
`define OUL_ADDR_CMD 3'h3

// Reset values of the three control registers.
`define OUL_FMT_RESET 8'h00
`define OUL_RATE_RESET 8'h00
`define OUL_CMD_RESET 8'h00

// Format register fields.
`define OUL_FMT_STOP_HI 7
`define OUL_FMT_STOP_LO 6
`define OUL_FMT_PAR_EVEN 5
`define OUL_FMT_PAR_EN 4
`define OUL_FMT_LEN_HI 3
`define OUL_FMT_LEN_LO 2
`define OUL_FMT_RESERVED_BIT 1
`define OUL_FMT_MODEM_CHANGE_IRQ_ENABLE 0

// Rate register nibbles.
`define OUL_RATE_TX_HI 7
`define OUL_RATE_TX_LO 4
`define OUL_RATE_RX_HI 3
`define OUL_RATE_RX_LO 0

// Command register fields.
`define OUL_CMD_MODE_HI 7
`define OUL_CMD_MODE_LO 6
`define OUL_CMD_RECEIVE_IRQ_ENABLE 5
`define OUL_CMD_ERRCLR 4
`define OUL_CMD_BRK 3
`define OUL_CMD_RECEIVER_ENABLE_BIT 2
`define OUL_CMD_TRANSMIT_IRQ_ENABLE 1
`define OUL_CMD_TRANSMITTER_ENABLE_BIT 0

// Line modes.
`define OUL_MODE_NORMAL 2'h0
`define OUL_MODE_ECHO 2'h1
`define OUL_MODE_LOCAL 2'h2
`define OUL_MODE_REMOTE 2'h3

// Status register bit positions.
`define OUL_ST_FRAME 5
`define OUL_ST_OVERRUN 4
`define OUL_ST_PARITY 3
`define OUL_ST_TXIDLE 2
`define OUL_ST_RXAVAIL 1
`define OUL_ST_HOLDEMPTY 0

// Input clock of the line in Hz.
`define OUL_CLK_HZ 20000000

// Twice each baud rate, so that 134.5 stays an integer; code 0 to 15.
`define OUL_BAUD2_0 100
`define OUL_BAUD2_1 150
`define OUL_BAUD2_2 220
`define OUL_BAUD2_3 269
`define OUL_BAUD2_4 300
`define OUL_BAUD2_5 600
`define OUL_BAUD2_6 1200
`define OUL_BAUD2_7 2400
`define OUL_BAUD2_8 3600
`define OUL_BAUD2_9 4000
`define OUL_BAUD2_10 4800
`define OUL_BAUD2_11 7200
`define OUL_BAUD2_12 9600
`define OUL_BAUD2_13 14400
`define OUL_BAUD2_14 19200
`define OUL_BAUD2_15 38400

// Stop length in half-bit units: one, one and a half, two.
`define OUL_STOP_HALF_1 4'h2
`define OUL_STOP_HALF_15 4'h3
`define OUL_STOP_HALF_2 4'h4

`endif

// File: src/oul_rx_fifo.v
`timescale 1ns/1ps

// Two-entry receive buffer; the oldest entry is always held in a register.
module oul_rx_fifo #(
  parameter WIDTH = 8
) (
  // Clock and reset.
  input wire sys_clk,
  input wire arst_n,
  // Control.
  input wire flush,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  // State.
  output reg [WIDTH-1:0] head_reg,
  output reg [1:0] count_reg
);

  // Second entry, behind the head.
  reg [WIDTH-1:0] tail_reg;

  // A push into a full buffer is dropped unless a pop comes in the same cycle; the caller flags the overrun.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      head_reg <= {WIDTH{1'b0}};
      tail_reg <= {WIDTH{1'b0}};
      count_reg <= 2'h0;
    end else if (flush) begin
      count_reg <= 2'h0;
    end else begin
      case ({push && (count_reg != 2'h2 || pop), pop && (count_reg != 2'h0)})
        2'b10: begin
          // Push only.
          if (count_reg == 2'h0) begin
            head_reg <= push_data;
          end else begin
            tail_reg <= push_data;
          end
          count_reg <= count_reg + 2'h1;
        end
        2'b01: begin
          // Pop only: the tail moves up.
          head_reg <= tail_reg;
          count_reg <= count_reg - 2'h1;
        end
        2'b11: begin
          // Pop and push together keep the count.
          if (count_reg == 2'h1) begin
            head_reg <= push_data;
          end else begin
            head_reg <= tail_reg;
            tail_reg <= push_data;
          end
        end
        default: begin
          // Nothing moves.
          count_reg <= count_reg;
        end
      endcase
    end
  end

endmodule // oul_rx_fifo

// File: src/oul_line.v
`timescale 1ns/1ps
`include "oul_regs.vh"

// Overview of operation
// - Shared mode address alternates format and rate.
// - Reset or command read returns pointer.
// - Format bits 7:6 choose stop length.
// - Format bits 5:4 choose even, odd, none.
// - Format bits 3:2 give five to eight bits.
// - Short characters right aligned, parity hidden.
// - Modem interrupt enable needs receive enable.
// - Rate nibbles set transmit and receive speeds.
// - Sixteen codes map to 50..19200 baud.
// - Command bits 7:6 choose line mode.
// - Receive enable offers character-available interrupt.
// - Error clear bit holds error flags clear.
// - Break spaces line after current character.
// - Break lasts whole bits, minimum enforced.
// - Receiver disable aborts and clears receive state.
// - Transmit enable offers holding-empty interrupt.
// - Transmitter disable finishes character, clears flags.
// - Holding character survives transmitter disable.
// - Normal mode receives and transmits automatically.
// - Echo copies input to output, no transmit.
// - Local loopback feeds transmitter into receiver.
// - Remote loopback returns input, flags suppressed.
module oul_line #(
  parameter CLK_HZ = `OUL_CLK_HZ
) (
  // Clock and reset.
  input wire sys_clk,
  input wire arst_n,
  // Host register port, synchronous one-cycle strobes.
  input wire bus_rd,
  input wire bus_wr,
  input wire [2:0] bus_addr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  // Serial pins.
  input wire rxd,
  output reg txd,
  // Interrupt sources offered to the scanner.
  output reg rx_irq_source,
  output reg tx_irq_source,
  output reg modem_change_irq_enable
);

  // Receive states.
  localparam RX_IDLE = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA = 3'h2;
  localparam RX_PAR = 3'h3;
  localparam RX_STOP = 3'h4;
  // Transmit states.
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam TX_STOP = 2'h2;
  localparam TX_BREAK = 2'h3;

  // Counter reload for half a bit at a rate code: its cycle count less one.
  function [19:0] half_bit;
    input [3:0] code;
    reg [31:0] b2;
    reg [31:0] q;
    begin
      case (code)
        4'h0: b2 = `OUL_BAUD2_0;
        4'h1: b2 = `OUL_BAUD2_1;
        4'h2: b2 = `OUL_BAUD2_2;
        4'h3: b2 = `OUL_BAUD2_3;
        4'h4: b2 = `OUL_BAUD2_4;
        4'h5: b2 = `OUL_BAUD2_5;
        4'h6: b2 = `OUL_BAUD2_6;
        4'h7: b2 = `OUL_BAUD2_7;
        4'h8: b2 = `OUL_BAUD2_8;
        4'h9: b2 = `OUL_BAUD2_9;
        4'ha: b2 = `OUL_BAUD2_10;
        4'hb: b2 = `OUL_BAUD2_11;
        4'hc: b2 = `OUL_BAUD2_12;
        4'hd: b2 = `OUL_BAUD2_13;
        4'he: b2 = `OUL_BAUD2_14;
        default: b2 = `OUL_BAUD2_15;
      endcase
      q = ((CLK_HZ / b2) > 1) ? (CLK_HZ / b2) - 1 : 32'h0;
      half_bit = q[19:0];
    end
  endfunction

  // Control registers and mode pointer.
  reg [7:0] line_format_config_reg;
  reg [7:0] line_rate_select_reg;
  reg [7:0] line_command_reg;
  reg mode_ptr_reg;
  // Input synchroniser.
  reg rxd_meta_reg;
  reg rxd_sync_reg;
  // Transmit side.
  reg [7:0] hold_data_reg;
  reg hold_full_reg;
  reg hold_empty_reg;
  reg tx_idle_reg;
  reg [1:0] tx_state_reg;
  reg [19:0] tx_cnt_reg;
  reg [3:0] tx_halves_reg;
  reg [8:0] tx_frame_reg;
  reg [3:0] tx_left_reg;
  reg [4:0] brk_bits_reg;
  reg tx_ser_reg;
  // Receive side.
  reg [2:0] rx_state_reg;
  reg [19:0] rx_cnt_reg;
  reg [3:0] rx_halves_reg;
  reg [7:0] rx_shift_reg;
  reg [3:0] rx_left_reg;
  reg rx_par_reg;
  reg frame_err_reg;
  reg overrun_err_reg;
  reg parity_err_reg;
  reg rx_push;
  reg [7:0] rx_word;
  wire [7:0] fifo_head;
  wire [1:0] fifo_count;

  // Decoded fields.
  wire [1:0] line_mode = line_format_config_reg[`OUL_FMT_STOP_HI:`OUL_FMT_STOP_LO] & 2'h0 |
    line_command_reg[`OUL_CMD_MODE_HI:`OUL_CMD_MODE_LO];
  wire [1:0] stop_code = line_format_config_reg[`OUL_FMT_STOP_HI:`OUL_FMT_STOP_LO];
  wire parity_en = line_format_config_reg[`OUL_FMT_PAR_EN];
  wire parity_even = line_format_config_reg[`OUL_FMT_PAR_EVEN];
  wire [3:0] nbits = {2'h0, line_format_config_reg[`OUL_FMT_LEN_HI:`OUL_FMT_LEN_LO]} + 4'h5;
  wire [19:0] tx_half = half_bit(line_rate_select_reg[`OUL_RATE_TX_HI:`OUL_RATE_TX_LO]);
  wire [19:0] rx_half = half_bit(line_rate_select_reg[`OUL_RATE_RX_HI:`OUL_RATE_RX_LO]);
  wire tx_en_eff = line_command_reg[`OUL_CMD_TRANSMITTER_ENABLE_BIT] &&
    (line_mode == `OUL_MODE_NORMAL || line_mode == `OUL_MODE_LOCAL);
  wire rx_en_eff = line_command_reg[`OUL_CMD_RECEIVER_ENABLE_BIT] && line_mode != `OUL_MODE_REMOTE;
  wire rx_in = (line_mode == `OUL_MODE_LOCAL) ? tx_ser_reg : rxd_sync_reg;
  wire send_break = line_command_reg[`OUL_CMD_BRK];
  wire rd_data = bus_rd && bus_addr == `OUL_ADDR_DATA;
  wire wr_data = bus_wr && bus_addr == `OUL_ADDR_DATA;
  wire mode_acc = (bus_rd || bus_wr) && bus_addr == `OUL_ADDR_MODE;
  wire rx_avail = fifo_count != 2'h0;
  wire [3:0] stop_halves = (stop_code == 2'h2) ? `OUL_STOP_HALF_15 :
    (stop_code == 2'h3) ? `OUL_STOP_HALF_2 : `OUL_STOP_HALF_1;
  // Shortest break in bits: twice the character length plus one.
  wire [4:0] brk_min = {nbits, 1'b1};

  // Two flip-flops bring the serial input into the clock domain.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // Register writes and the shared mode pointer.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_format_config_reg <= `OUL_FMT_RESET;
      line_rate_select_reg <= `OUL_RATE_RESET;
      line_command_reg <= `OUL_CMD_RESET;
      mode_ptr_reg <= 1'b0;
    end else begin
      if (mode_acc) begin
        // Any access goes to the pointed register, then the pointer flips.
        mode_ptr_reg <= ~mode_ptr_reg;
        if (bus_wr && !mode_ptr_reg) begin
          line_format_config_reg <= bus_wdata & 8'hfd;
        end else if (bus_wr) begin
          line_rate_select_reg <= bus_wdata;
        end
      end else if (bus_rd && bus_addr == `OUL_ADDR_CMD) begin
        mode_ptr_reg <= 1'b0;
      end
      if (bus_wr && bus_addr == `OUL_ADDR_CMD) begin
        if (bus_wdata[`OUL_CMD_MODE_HI:`OUL_CMD_MODE_LO] == `OUL_MODE_REMOTE) begin
          // Remote loopback keeps both enables cleared.
          line_command_reg <= bus_wdata & 8'hfa;
        end else begin
          line_command_reg <= bus_wdata;
        end
      end
    end
  end

  // Host read data, registered; reading the data address pops the buffer.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        `OUL_ADDR_DATA: bus_rdata <= fifo_head;
        `OUL_ADDR_STATUS: bus_rdata <= {2'h0, frame_err_reg, overrun_err_reg, parity_err_reg,
          tx_idle_reg, rx_avail, hold_empty_reg};
        `OUL_ADDR_MODE: bus_rdata <= mode_ptr_reg ? line_rate_select_reg : line_format_config_reg;
        `OUL_ADDR_CMD: bus_rdata <= line_command_reg;
        default: bus_rdata <= 8'h00;
      endcase
    end
  end

  // Holding register and the two transmit-ready flags.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_data_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      hold_empty_reg <= 1'b0;
      tx_idle_reg <= 1'b0;
    end else begin
      if (wr_data) begin
        // A write while full simply overwrites the waiting character.
        hold_data_reg <= bus_wdata;
        hold_full_reg <= 1'b1;
      end else if (tx_state_reg == TX_IDLE && hold_full_reg && tx_en_eff && !send_break) begin
        hold_full_reg <= 1'b0;
      end
      // Disable clears the flag but never the waiting character.
      hold_empty_reg <= tx_en_eff && !hold_full_reg && !wr_data;
      if (wr_data || !tx_en_eff) begin
        tx_idle_reg <= 1'b0;
      end else if (tx_state_reg == TX_STOP && tx_cnt_reg == 20'h0 && tx_halves_reg == 4'h1 &&
        !hold_full_reg) begin
        tx_idle_reg <= 1'b1;
      end
    end
  end

  // Serialiser: each element lasts a number of half-bit periods.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 20'h0;
      tx_halves_reg <= 4'h0;
      tx_frame_reg <= 9'h000;
      tx_left_reg <= 4'h0;
      brk_bits_reg <= 5'h00;
      tx_ser_reg <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_ser_reg <= 1'b1;
          tx_cnt_reg <= tx_half;
          tx_halves_reg <= 4'h2;
          if (send_break) begin
            // Spacing begins only between characters.
            tx_ser_reg <= 1'b0;
            brk_bits_reg <= 5'h00;
            tx_state_reg <= TX_BREAK;
          end else if (hold_full_reg && tx_en_eff) begin
            // Start bit, then data with parity just above it.
            tx_ser_reg <= 1'b0;
            tx_frame_reg <= ({1'b0, hold_data_reg & ~(8'hff << nbits)} |
              ({8'h00, parity_en & (parity_even ~^ (^(hold_data_reg & ~(8'hff << nbits))))} << nbits));
            tx_left_reg <= nbits + {3'h0, parity_en};
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT, TX_STOP: begin
          // A started character always finishes, even if disabled.
          if (tx_cnt_reg != 20'h0) begin
            tx_cnt_reg <= tx_cnt_reg - 20'h1;
          end else begin
            tx_cnt_reg <= tx_half;
            if (tx_halves_reg > 4'h1) begin
              tx_halves_reg <= tx_halves_reg - 4'h1;
            end else if (tx_state_reg == TX_STOP) begin
              tx_state_reg <= TX_IDLE;
            end else if (tx_left_reg == 4'h0) begin
              tx_ser_reg <= 1'b1;
              tx_halves_reg <= stop_halves;
              tx_state_reg <= TX_STOP;
            end else begin
              tx_ser_reg <= tx_frame_reg[0];
              tx_frame_reg <= {1'b0, tx_frame_reg[8:1]};
              tx_left_reg <= tx_left_reg - 4'h1;
              tx_halves_reg <= 4'h2;
            end
          end
        end
        TX_BREAK: begin
          // Break ends on a bit boundary and not before its minimum.
          if (tx_cnt_reg != 20'h0) begin
            tx_cnt_reg <= tx_cnt_reg - 20'h1;
          end else begin
            tx_cnt_reg <= tx_half;
            if (tx_halves_reg > 4'h1) begin
              tx_halves_reg <= tx_halves_reg - 4'h1;
            end else begin
              tx_halves_reg <= 4'h2;
              if (brk_bits_reg != 5'h1f) begin
                brk_bits_reg <= brk_bits_reg + 5'h01;
              end
              if (!send_break && brk_bits_reg + 5'h01 >= brk_min) begin
                tx_ser_reg <= 1'b1;
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Deserialiser; disabling the receiver drops it back to idle at once.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 20'h0;
      rx_halves_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_left_reg <= 4'h0;
      rx_par_reg <= 1'b0;
    end else if (!rx_en_eff) begin
      rx_state_reg <= RX_IDLE;
    end else if (rx_state_reg == RX_IDLE) begin
      rx_cnt_reg <= rx_half;
      rx_halves_reg <= 4'h1;
      rx_left_reg <= nbits;
      if (!rx_in) begin
        rx_state_reg <= RX_START;
      end
    end else if (rx_cnt_reg != 20'h0) begin
      rx_cnt_reg <= rx_cnt_reg - 20'h1;
    end else if (rx_halves_reg > 4'h1) begin
      rx_cnt_reg <= rx_half;
      rx_halves_reg <= rx_halves_reg - 4'h1;
    end else begin
      // Sample point, in the middle of each bit.
      rx_cnt_reg <= rx_half;
      rx_halves_reg <= 4'h2;
      case (rx_state_reg)
        RX_START: rx_state_reg <= rx_in ? RX_IDLE : RX_DATA;
        RX_DATA: begin
          rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
          rx_left_reg <= rx_left_reg - 4'h1;
          if (rx_left_reg == 4'h1) begin
            rx_state_reg <= parity_en ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          rx_par_reg <= rx_in;
          rx_state_reg <= RX_STOP;
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Character completion: right-aligned word and its checks.
  always @* begin
    rx_word = rx_shift_reg >> (4'h8 - nbits);
    rx_push = rx_en_eff && rx_state_reg == RX_STOP && rx_cnt_reg == 20'h0 && rx_halves_reg == 4'h1;
  end

  // Error flags; the clear conditions win, since they hold the flags down.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_err_reg <= 1'b0;
      overrun_err_reg <= 1'b0;
      parity_err_reg <= 1'b0;
    end else if (!rx_en_eff || line_command_reg[`OUL_CMD_ERRCLR]) begin
      frame_err_reg <= 1'b0;
      overrun_err_reg <= 1'b0;
      parity_err_reg <= 1'b0;
    end else if (rx_push) begin
      frame_err_reg <= !rx_in;
      overrun_err_reg <= overrun_err_reg | (fifo_count == 2'h2 && !rd_data);
      parity_err_reg <= parity_en && ((^rx_word) ^ rx_par_reg) != !parity_even;
    end else if (rd_data) begin
      parity_err_reg <= 1'b0;
    end
  end

  // Two-entry receive buffer.
  oul_rx_fifo #(
    .WIDTH(8)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .flush(!rx_en_eff),
    .push(rx_push),
    .push_data(rx_word),
    .pop(rd_data),
    .head_reg(fifo_head),
    .count_reg(fifo_count)
  );

  // Serial output pin and interrupt sources, all registered.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txd <= 1'b1;
      rx_irq_source <= 1'b0;
      tx_irq_source <= 1'b0;
      modem_change_irq_enable <= 1'b0;
    end else begin
      case (line_mode)
        `OUL_MODE_ECHO: txd <= rxd_sync_reg;
        `OUL_MODE_LOCAL: txd <= 1'b1;
        `OUL_MODE_REMOTE: txd <= rxd_sync_reg;
        default: txd <= tx_ser_reg;
      endcase
      rx_irq_source <= line_command_reg[`OUL_CMD_RECEIVE_IRQ_ENABLE] && rx_avail && rx_en_eff;
      tx_irq_source <= line_command_reg[`OUL_CMD_TRANSMIT_IRQ_ENABLE] && hold_empty_reg;
      modem_change_irq_enable <= line_format_config_reg[`OUL_FMT_MODEM_CHANGE_IRQ_ENABLE] &&
        line_command_reg[`OUL_CMD_RECEIVE_IRQ_ENABLE];
    end
  end

endmodule // oul_line

// File: tb/oul_line_monitor.sv
`timescale 1ns/1ps
`include "oul_regs.vh"

// Watches one line from its ports only.
module oul_line_monitor (
  // Clock and reset.
  input wire sys_clk,
  input wire arst_n,
  // Host port.
  input wire bus_rd,
  input wire bus_wr,
  input wire [2:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  // Serial pins.
  input wire rxd,
  input wire txd,
  // Interrupt sources.
  input wire rx_irq_source,
  input wire tx_irq_source,
  input wire modem_change_irq_enable
);
  reg [7:0] fmt_sh; // Expected format register.
  reg [7:0] rate_sh; // Expected rate register.
  reg [7:0] cmd_sh; // Expected command register.
  reg ptr_sh; // Expected pointer, high selects rate.
  reg [2:0] quiet_cnt; // Cycles since a write, saturating at 7.
  wire mode_acc = (bus_rd || bus_wr) && bus_addr == `OUL_ADDR_MODE;
  wire cmd_wr = bus_wr && bus_addr == `OUL_ADDR_CMD;

  // Shadows follow host writes; remote loopback stores the enables clear.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_sh <= 8'h00;
      rate_sh <= 8'h00;
      cmd_sh <= 8'h00;
      ptr_sh <= 1'b0;
      quiet_cnt <= 3'h7;
    end else begin
      quiet_cnt <= bus_wr ? 3'h0 : quiet_cnt + {2'h0, quiet_cnt != 3'h7};
      if (mode_acc && bus_wr && !ptr_sh) fmt_sh <= bus_wdata & 8'hfd;
      if (mode_acc && bus_wr && ptr_sh) rate_sh <= bus_wdata;
      if (cmd_wr) cmd_sh <= (bus_wdata[7:6] == `OUL_MODE_REMOTE) ? bus_wdata & 8'hfa : bus_wdata;
      if (mode_acc) ptr_sh <= !ptr_sh;
      else if (bus_rd && bus_addr == `OUL_ADDR_CMD) ptr_sh <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_mode_rd;
    bus_rd && bus_addr == `OUL_ADDR_MODE;
  endsequence
  sequence s_cmd_rd;
    bus_rd && bus_addr == `OUL_ADDR_CMD;
  endsequence
  property p_mode_read;
    s_mode_rd |=> bus_rdata == ($past(ptr_sh) ? $past(rate_sh) : $past(fmt_sh));
  endproperty
  property p_cmd_read;
    s_cmd_rd |=> bus_rdata == $past(cmd_sh);
  endproperty
  property p_ptr_home;
    s_cmd_rd ##2 s_mode_rd |=> bus_rdata == $past(fmt_sh);
  endproperty
  property p_modem_change_irq_enable;
    quiet_cnt == 3'h7 |-> modem_change_irq_enable == (fmt_sh[0] && cmd_sh[5]);
  endproperty
  property p_tx_irq_off;
    quiet_cnt == 3'h7 && (!cmd_sh[1] || cmd_sh[6]) |-> !tx_irq_source;
  endproperty
  property p_rx_irq_off;
    quiet_cnt == 3'h7 && !(cmd_sh[5] && cmd_sh[2]) |-> !rx_irq_source;
  endproperty
  property p_local_mark;
    quiet_cnt == 3'h7 && cmd_sh[7:6] == `OUL_MODE_LOCAL |-> txd;
  endproperty
  property p_echo_copy;
    (quiet_cnt == 3'h7 && cmd_sh[6] && $stable(rxd))[*6] |-> txd == rxd;
  endproperty

  a_mode_read: assert property (p_mode_read) else $error("mode read mismatch");
  a_cmd_read: assert property (p_cmd_read) else $error("command read mismatch");
  a_ptr_home: assert property (p_ptr_home) else $error("pointer not home");
  a_modem_change_irq_enable: assert property (p_modem_change_irq_enable) else $error("modem enable wrong");
  a_tx_irq_off: assert property (p_tx_irq_off) else $error("tx source stray");
  a_rx_irq_off: assert property (p_rx_irq_off) else $error("rx source stray");
  a_local_mark: assert property (p_local_mark) else $error("txd not marking");
  a_echo_copy: assert property (p_echo_copy) else $error("txd not echoing");
endmodule // oul_line_monitor

bind oul_line oul_line_monitor oul_line_monitor_inst (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .bus_rd(bus_rd),
  .bus_wr(bus_wr),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata),
  .rxd(rxd),
  .txd(txd),
  .rx_irq_source(rx_irq_source),
  .tx_irq_source(tx_irq_source),
  .modem_change_irq_enable(modem_change_irq_enable)
);

// File: tb/oul_remote_term.sv
`timescale 1ns/1ps

// Remote terminal on the serial pair.
module oul_remote_term #(
  parameter BIT_NS = 1000
) (
  // Serial pins seen from the far end.
  input wire txd,
  output reg rxd,
  // Ten samples after each start edge, and a frame count.
  output reg [9:0] cap,
  output reg [7:0] cap_cnt
);
  integer i;

  // Idle line is marking.
  initial begin
    rxd = 1'b1;
    cap = 10'h000;
    cap_cnt = 8'h00;
  end

  // Sends a start bit, n bits LSB first, then two stop times.
  task send(input [9:0] bits, input integer n);
    begin
      rxd = 1'b0;
      #(BIT_NS);
      for (i = 0; i < n; i = i + 1) begin
        rxd = bits[i];
        #(BIT_NS);
      end
      rxd = 1'b1;
      #(2 * BIT_NS);
    end
  endtask

  // Samples bit centres after each falling start edge.
  always @(negedge txd) begin : catch_frame
    integer k;
    #(BIT_NS / 2);
    for (k = 0; k < 10; k = k + 1) begin
      #(BIT_NS);
      cap = {txd, cap[9:1]};
    end
    cap_cnt = cap_cnt + 8'h01;
  end
endmodule // oul_remote_term

// File: tb/oul_line_tb_top.sv
`timescale 1ns/1ps

`define CHK(g, e) \
  begin \
    total_checks = total_checks + 1; \
    if ((g) !== (e)) begin \
      error_cnt = error_cnt + 1; \
      $display("MISMATCH at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end

// Drives one line from the host side against a remote terminal.
module oul_line_tb_top;
  reg sys_clk;
  reg arst_n;
  reg bus_rd;
  reg bus_wr;
  reg [2:0] bus_addr;
  reg [7:0] bus_wdata;
  wire [7:0] bus_rdata;
  wire rxd;
  wire txd;
  wire rx_irq_source;
  wire tx_irq_source;
  wire modem_change_irq_enable;
  wire [9:0] cap;
  wire [7:0] cap_cnt;
  integer error_cnt;
  integer total_checks;
  integer cyc;
  integer k;
  integer m;

  oul_line #(.CLK_HZ(384000)) oul_line_inst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .bus_rd(bus_rd),
    .bus_wr(bus_wr),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata),
    .rxd(rxd),
    .txd(txd),
    .rx_irq_source(rx_irq_source),
    .tx_irq_source(tx_irq_source),
    .modem_change_irq_enable(modem_change_irq_enable)
  );

  // Code 15 gives 20 cycles a bit at this clock rate.
  oul_remote_term #(.BIT_NS(1000)) oul_remote_term_inst (
    .txd(txd),
    .rxd(rxd),
    .cap(cap),
    .cap_cnt(cap_cnt)
  );

  // Free-running 50 ns clock.
  always #25 sys_clk = ~sys_clk;

  // Cuts a hang short.
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end

  // Writes one register; the strobe drops before the next access.
  task wr(input [2:0] a, input [7:0] d);
    begin
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge sys_clk);
      bus_wr = 1'b0;
      @(negedge sys_clk);
    end
  endtask

  // Reads one register and compares the masked value.
  task rd(input [2:0] a, input [7:0] msk, input [7:0] e);
    begin
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge sys_clk);
      bus_rd = 1'b0;
      @(negedge sys_clk);
      `CHK(bus_rdata & msk, e)
    end
  endtask

  // Waits a bounded time for the n-th frame at the far end.
  task wait_cap(input [7:0] n);
    begin
      for (k = 0; k < 600 && cap_cnt < n; k = k + 1) @(negedge sys_clk);
      `CHK(cap_cnt, n)
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task final_report;
    begin
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask

  // Main sequence.
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 3'h0;
    bus_wdata = 8'h00;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    rd(3'h3, 8'hff, 8'h00);
    rd(3'h2, 8'hff, 8'h00);
    rd(3'h2, 8'hff, 8'h00);
    rd(3'h1, 8'hff, 8'h00);
    rd(3'h5, 8'hff, 8'h00);
    // Mode address is used with plain accesses only.
    wr(3'h2, 8'h5e);
    rd(3'h3, 8'hff, 8'h00);
    rd(3'h2, 8'hff, 8'h5c);
    wr(3'h2, 8'hff);
    rd(3'h2, 8'hff, 8'h5c);
    rd(3'h2, 8'hff, 8'hff);
    // Eight bits, odd parity, one stop.
    wr(3'h3, 8'h03);
    rd(3'h1, 8'h01, 8'h01);
    `CHK(tx_irq_source, 1'b1)
    wr(3'h0, 8'ha5);
    wait_cap(8'd1);
    `CHK(cap, 10'h3a5)
    // Holding byte waits while the transmitter is off.
    wr(3'h3, 8'h02);
    wr(3'h0, 8'h3c);
    repeat (300) @(negedge sys_clk);
    `CHK(cap_cnt, 8'd1)
    rd(3'h1, 8'h01, 8'h00);
    wr(3'h3, 8'h03);
    wait_cap(8'd2);
    `CHK(cap, 10'h33c)
    // Idle flag once the stop bit ends with the holding register empty.
    repeat (20) @(negedge sys_clk);
    rd(3'h1, 8'h05, 8'h05);
    // Break of at least seventeen bit times.
    wr(3'h3, 8'h0b);
    repeat (40) @(negedge sys_clk);
    `CHK(txd, 1'b0)
    wr(3'h3, 8'h03);
    repeat (250) @(negedge sys_clk);
    `CHK(txd, 1'b0)
    repeat (120) @(negedge sys_clk);
    `CHK(txd, 1'b1)
    `CHK(cap, 10'h000)
    // Six bits, even parity, modem enable set.
    wr(3'h2, 8'h75);
    wr(3'h2, 8'hff);
    wr(3'h3, 8'h27);
    oul_remote_term_inst.send(10'h06a, 7);
    repeat (30) @(negedge sys_clk);
    `CHK(rx_irq_source, 1'b1)
    `CHK(modem_change_irq_enable, 1'b1)
    rd(3'h1, 8'h3a, 8'h02);
    rd(3'h0, 8'hff, 8'h2a);
    oul_remote_term_inst.send(10'h02a, 7);
    repeat (30) @(negedge sys_clk);
    rd(3'h1, 8'h08, 8'h08);
    wr(3'h3, 8'h37);
    rd(3'h1, 8'h38, 8'h00);
    rd(3'h3, 8'hff, 8'h37);
    rd(3'h0, 8'hff, 8'h2a);
    oul_remote_term_inst.send(10'h06a, 7);
    repeat (30) @(negedge sys_clk);
    rd(3'h1, 8'h02, 8'h02);
    wr(3'h3, 8'h23);
    rd(3'h1, 8'h02, 8'h00);
    `CHK(rx_irq_source, 1'b0)
    // Local loopback keeps the pin marking.
    wr(3'h3, 8'ha7);
    wr(3'h0, 8'hd5);
    repeat (300) @(negedge sys_clk);
    `CHK(cap_cnt, 8'd3)
    rd(3'h0, 8'hff, 8'h15);
    // Echo then remote loopback return the input.
    for (m = 1; m < 4; m = m + 2) begin
      wr(3'h3, {m[1:0], 6'h27});
      oul_remote_term_inst.send(10'h06a, 7);
      repeat (30) @(negedge sys_clk);
      `CHK(cap, 10'h3ea)
      rd(3'h1, 8'h07, (m == 1) ? 8'h02 : 8'h00);
    end
    final_report;
  end
endmodule // oul_line_tb_top
